/* ecs_defines.svh */
// Register offsets, field positions, masks and reset values of the event capture bank
`ifndef ECS_DEFINES_SVH
`define ECS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ECS_OFF_SYS_EN 8'h04
`define ECS_OFF_REG_EN 8'h05
`define ECS_OFF_TRX_EN 8'h23
`define ECS_OFF_TRX2_EN 8'h34
`define ECS_OFF_WAKE_EN 8'h4c
`define ECS_OFF_GLOBAL 8'h60
`define ECS_OFF_WAKE_ST 8'h64
`define ECS_OFF_BUS_ST 8'h65
`define ECS_OFF_REG_ST 8'h66

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define ECS_RST_SYS_EN 8'h01
`define ECS_RST_REG_EN 8'h10
`define ECS_RST_TRX_EN 8'h00
`define ECS_RST_TRX2_EN 8'h00
`define ECS_RST_WAKE_EN 8'h00
`define ECS_MSK_SYS_EN 8'h4f
`define ECS_MSK_REG_EN 8'h7f
`define ECS_MSK_TRX_EN 8'h57
`define ECS_MSK_TRX2_EN 8'h01
`define ECS_MSK_WAKE_EN 8'h07

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ECS_SYS_BATT_UV 6
`define ECS_SYS_IO_UV 3
`define ECS_SYS_PREWARN 2
`define ECS_SYS_SPI_FAIL 1
`define ECS_SYS_RST_SEL 0
`define ECS_REG_LH_HI 6
`define ECS_REG_LH_LO 4
`define ECS_REG_MAIN_OV 3
`define ECS_REG_MAIN_UV 2
`define ECS_REG_SENS_OV 1
`define ECS_REG_SENS_UV 0
`define ECS_TRX_PN_OSC 6
`define ECS_TRX_SILENCE 4
`define ECS_TRX_LIN_WAKE 2
`define ECS_TRX_CAN_FAIL 1
`define ECS_TRX_CAN_WAKE 0
`define ECS_WAKE_EXT 2
`define ECS_WAKE_RISE 1
`define ECS_WAKE_FALL 0
`define ECS_GLB_BUS 5
`define ECS_GLB_WAKE 3
`define ECS_GLB_REG 1
`define ECS_LH_OFF_CODE 3'b110

// Flag widths of the three status registers
`define ECS_WAKE_W 3
`define ECS_BUS_W 2
`define ECS_REGST_W 8

`endif

/* ecs_pkg.sv */
// Types shared by the event capture bank and its users
package ecs_pkg;

  // Raw detector indications, all levels or one-cycle pulses sampled on sys_clk
  typedef struct packed {
    logic ext_wake;      // Wake from the secondary LIN transceiver
    logic wake_pin;      // Level of the wake input pin
    logic bus_dom_to;    // CAN bus dominant time-out detected
    logic bus_short;     // CAN bus short-circuit detected
    logic main_ot_sd;    // Main regulator over shutdown temperature
    logic main_ot_pw;    // Main regulator over prewarning temperature
    logic main_ov;       // Main supply overvoltage detector
    logic main_uv;       // Main supply undervoltage detector
    logic sens_ot_sd;    // Sensor regulator over shutdown temperature
    logic sens_ot_pw;    // Sensor regulator over prewarning temperature
    logic sens_ov;       // Sensor supply overvoltage, already debounced
    logic sens_uv;       // Sensor supply undervoltage, already debounced
    logic uv_sleep;      // Undervoltage forces Sleep mode
  } ecs_evt_s;

  // Control levels handed to the rest of the chip
  typedef struct packed {
    logic batt_uv_en;
    logic io_uv_en;
    logic spi_fail_en;
    logic reset_threshold_select;
    logic limp_home_ov_en;
    logic pn_osc_fail_en;
    logic bus_silence_en;
    logic lin_wake_en;
    logic can_fail_en;
    logic can_wake_en;
    logic rx_clamp_en;
    logic sensor_reg_enable;
    logic wake_summary_bit;
    logic bus_failure_summary_bit;
    logic regulator_summary_bit;
  } ecs_ctl_s;

  // Whole state of the bank apart from the flags
  typedef struct packed {
    logic [7:0] sys_en;
    logic [7:0] reg_en;
    logic [7:0] trx_en;
    logic [7:0] trx2_en;
    logic [7:0] wake_en;
    logic [7:0] rdata;
  } ecs_state_s;

endpackage

/* ecs_sticky_flags.sv */
// Row of write-one-to-clear event flags where a set beats a same-cycle clear
`timescale 1ns/1ps
module ecs_sticky_flags #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Flag control
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flag state
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  initial begin
    if (W < 1 || W > 8) begin
      $error("ecs_sticky_flags: W must be 1 to 8");
    end
  end

  // Set wins so an event in the clearing cycle is never lost
  always_comb begin
    flags_next = (flags_reg & ~clr) | set;
  end

  // Flags start cleared
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

/* ecs_edge_detect.sv */
// Rising and falling edge pulses of a synchronous level
`timescale 1ns/1ps
module ecs_edge_detect (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Level in
  input wire logic level,
  // Edge pulses
  output logic rise,
  output logic fall
);

  logic prev_reg;
  logic prev_next;
  logic valid_reg;
  logic valid_next;

  // The first cycle after reset only loads the level, so no false edge appears
  always_comb begin
    prev_next = level;
    valid_next = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prev_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      valid_reg <= valid_next;
    end
  end

  assign rise = valid_reg && level && !prev_reg;
  assign fall = valid_reg && !level && prev_reg;

endmodule

/* ecs_event_bank.sv */
// Event capture enables, sticky event flags and summary bits of the supply chip
//
// Contract
// - External wake flag sets on secondary LIN wake when its capture is enabled.
// - Local wake rise flag sets on a wake pin rising edge when enabled.
// - Local wake fall flag sets on a wake pin falling edge when enabled.
// - Undervoltage forced Sleep clears both local wake edge flags.
// - Bus dominant time-out flag sets when that time-out is detected.
// - Bus short flag sets when a bus short-circuit is detected.
// - Main regulator overtemperature flag sets on shutdown threshold, no enable needed.
// - Main regulator prewarning flag sets only when prewarning capture is enabled.
// - Main supply overvoltage flag sets when its capture is enabled.
// - Main supply undervoltage flag sets when its capture is enabled.
// - Sensor shutdown flag sets always; sensor prewarning needs its capture enable.
// - Sensor overvoltage flag sets when enabled; sensor regulator off while it stands.
// - Sensor undervoltage flag sets on debounced undervoltage when enabled.
// - Status flags clear when the host writes a one to them; forced Sleep also clears the two local wake edge flags.
// - System enable register holds battery, IO, prewarning and serial failure enables.
// - Reset threshold select resets to one and picks the reset trigger level.
// - Limp-home overvoltage control disables only for code 110.
// - Regulator enable register holds main and sensor over and undervoltage enables.
// - Transceiver enables: oscillator fail bit 6, bus silence bit 4, LIN wake bit 2.
// - Transceiver enables: CAN failure bit 1, CAN wake bit 0.
// - Second transceiver register bit 0 enables receive recessive clamp detection.
// - Wake enable register: rise bit 1, fall bit 0, external bit 2.
// - Global status shows wake, bus failure and regulator summaries of their flags.
`timescale 1ns/1ps
`include "ecs_defines.svh"
module ecs_event_bank #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register access from the serial frame decoder
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Detector indications
  input wire ecs_pkg::ecs_evt_s evt,
  // Control and summary levels
  output ecs_pkg::ecs_ctl_s ctl
);
  import ecs_pkg::*;

  ecs_state_s st_reg;
  ecs_state_s st_next;

  logic [`ECS_WAKE_W-1:0] wake_flags;
  logic [`ECS_BUS_W-1:0] bus_flags;
  logic [`ECS_REGST_W-1:0] reg_flags;
  logic [`ECS_WAKE_W-1:0] wake_set;
  logic [`ECS_WAKE_W-1:0] wake_clr;
  logic [`ECS_BUS_W-1:0] bus_set;
  logic [`ECS_BUS_W-1:0] bus_clr;
  logic [`ECS_REGST_W-1:0] reg_set;
  logic [`ECS_REGST_W-1:0] reg_clr;
  logic [7:0] glob;
  logic [7:0] addr8;
  logic wake_rise;
  logic wake_fall;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Offsets are eight bits wide, so a narrower address cannot reach the bank
  initial begin
    if (ADDR_W < 8) begin
      $error("ecs_event_bank: ADDR_W must be at least 8");
    end
  end

  assign addr8 = reg_addr[7:0];

  // ----------------------------------------------------------------
  // Wake pin edges
  // ----------------------------------------------------------------
  ecs_edge_detect u_wake_edge (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .level (evt.wake_pin),
    .rise (wake_rise),
    .fall (wake_fall)
  );

  // ----------------------------------------------------------------
  // Flag set terms
  // ----------------------------------------------------------------
  // Each set term is the detector gated by its capture enable where one exists
  always_comb begin
    wake_set = '0;
    wake_set[`ECS_WAKE_EXT] = evt.ext_wake && st_reg.wake_en[`ECS_WAKE_EXT];
    wake_set[`ECS_WAKE_RISE] = wake_rise && st_reg.wake_en[`ECS_WAKE_RISE];
    wake_set[`ECS_WAKE_FALL] = wake_fall && st_reg.wake_en[`ECS_WAKE_FALL];
    bus_set = {evt.bus_dom_to, evt.bus_short};
    reg_set[7] = evt.main_ot_sd;
    reg_set[6] = evt.main_ot_pw && st_reg.sys_en[`ECS_SYS_PREWARN];
    reg_set[5] = evt.main_ov && st_reg.reg_en[`ECS_REG_MAIN_OV];
    reg_set[4] = evt.main_uv && st_reg.reg_en[`ECS_REG_MAIN_UV];
    reg_set[3] = evt.sens_ot_sd;
    reg_set[2] = evt.sens_ot_pw && st_reg.sys_en[`ECS_SYS_PREWARN];
    reg_set[1] = evt.sens_ov && st_reg.reg_en[`ECS_REG_SENS_OV];
    reg_set[0] = evt.sens_uv && st_reg.reg_en[`ECS_REG_SENS_UV];
  end

  // ----------------------------------------------------------------
  // Flag clear terms
  // ----------------------------------------------------------------
  // Only written ones and forced Sleep clear a flag; written zeros and reserved bits have no effect
  always_comb begin
    wake_clr = '0;
    bus_clr = '0;
    reg_clr = '0;
    if (reg_wr && addr8 == `ECS_OFF_WAKE_ST && reg_addr == ADDR_W'(addr8)) begin
      wake_clr = reg_wdata[`ECS_WAKE_W-1:0];
    end else if (reg_wr && addr8 == `ECS_OFF_BUS_ST && reg_addr == ADDR_W'(addr8)) begin
      bus_clr = reg_wdata[`ECS_BUS_W-1:0];
    end else if (reg_wr && addr8 == `ECS_OFF_REG_ST && reg_addr == ADDR_W'(addr8)) begin
      reg_clr = reg_wdata;
    end
    // Forced Sleep drops stale local wake edges so the chip can wake cleanly
    if (evt.uv_sleep) begin
      wake_clr[`ECS_WAKE_RISE] = 1'b1;
      wake_clr[`ECS_WAKE_FALL] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status flag rows
  // ----------------------------------------------------------------
  ecs_sticky_flags #(.W(`ECS_WAKE_W)) u_wake_flags (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .set (wake_set),
    .clr (wake_clr),
    .flags (wake_flags)
  );

  ecs_sticky_flags #(.W(`ECS_BUS_W)) u_bus_flags (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .set (bus_set),
    .clr (bus_clr),
    .flags (bus_flags)
  );

  ecs_sticky_flags #(.W(`ECS_REGST_W)) u_reg_flags (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .set (reg_set),
    .clr (reg_clr),
    .flags (reg_flags)
  );

  // ----------------------------------------------------------------
  // Global summary
  // ----------------------------------------------------------------
  // Only the three summaries this bank owns; other summary bits read zero here
  always_comb begin
    glob = 8'h00;
    glob[`ECS_GLB_WAKE] = |wake_flags;
    glob[`ECS_GLB_BUS] = |bus_flags;
    glob[`ECS_GLB_REG] = |reg_flags;
  end

  // ----------------------------------------------------------------
  // Enable registers and read data
  // ----------------------------------------------------------------
  // Writes are masked so reserved bits stay zero; reads answer one cycle later
  always_comb begin
    st_next = st_reg;
    if (reg_wr && reg_addr == ADDR_W'(addr8)) begin
      if (addr8 == `ECS_OFF_SYS_EN) begin
        st_next.sys_en = reg_wdata & `ECS_MSK_SYS_EN;
      end else if (addr8 == `ECS_OFF_REG_EN) begin
        st_next.reg_en = reg_wdata & `ECS_MSK_REG_EN;
      end else if (addr8 == `ECS_OFF_TRX_EN) begin
        st_next.trx_en = reg_wdata & `ECS_MSK_TRX_EN;
      end else if (addr8 == `ECS_OFF_TRX2_EN) begin
        st_next.trx2_en = reg_wdata & `ECS_MSK_TRX2_EN;
      end else if (addr8 == `ECS_OFF_WAKE_EN) begin
        st_next.wake_en = reg_wdata & `ECS_MSK_WAKE_EN;
      end
    end
    if (reg_rd) begin
      if (reg_addr != ADDR_W'(addr8)) begin
        st_next.rdata = 8'h00;
      end else if (addr8 == `ECS_OFF_SYS_EN) begin
        st_next.rdata = st_reg.sys_en;
      end else if (addr8 == `ECS_OFF_REG_EN) begin
        st_next.rdata = st_reg.reg_en;
      end else if (addr8 == `ECS_OFF_TRX_EN) begin
        st_next.rdata = st_reg.trx_en;
      end else if (addr8 == `ECS_OFF_TRX2_EN) begin
        st_next.rdata = st_reg.trx2_en;
      end else if (addr8 == `ECS_OFF_WAKE_EN) begin
        st_next.rdata = st_reg.wake_en;
      end else if (addr8 == `ECS_OFF_GLOBAL) begin
        st_next.rdata = glob;
      end else if (addr8 == `ECS_OFF_WAKE_ST) begin
        st_next.rdata = {5'h00, wake_flags};
      end else if (addr8 == `ECS_OFF_BUS_ST) begin
        st_next.rdata = {6'h00, bus_flags};
      end else if (addr8 == `ECS_OFF_REG_ST) begin
        st_next.rdata = reg_flags;
      end else begin
        st_next.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg.sys_en <= `ECS_RST_SYS_EN;
      st_reg.reg_en <= `ECS_RST_REG_EN;
      st_reg.trx_en <= `ECS_RST_TRX_EN;
      st_reg.trx2_en <= `ECS_RST_TRX2_EN;
      st_reg.wake_en <= `ECS_RST_WAKE_EN;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_comb begin
    ctl.batt_uv_en = st_reg.sys_en[`ECS_SYS_BATT_UV];
    ctl.io_uv_en = st_reg.sys_en[`ECS_SYS_IO_UV];
    ctl.spi_fail_en = st_reg.sys_en[`ECS_SYS_SPI_FAIL];
    ctl.reset_threshold_select = st_reg.sys_en[`ECS_SYS_RST_SEL];
    ctl.limp_home_ov_en = st_reg.reg_en[`ECS_REG_LH_HI:`ECS_REG_LH_LO] != `ECS_LH_OFF_CODE;
    ctl.pn_osc_fail_en = st_reg.trx_en[`ECS_TRX_PN_OSC];
    ctl.bus_silence_en = st_reg.trx_en[`ECS_TRX_SILENCE];
    ctl.lin_wake_en = st_reg.trx_en[`ECS_TRX_LIN_WAKE];
    ctl.can_fail_en = st_reg.trx_en[`ECS_TRX_CAN_FAIL];
    ctl.can_wake_en = st_reg.trx_en[`ECS_TRX_CAN_WAKE];
    ctl.rx_clamp_en = st_reg.trx2_en[0];
    // Sensor regulator stays off until the host acknowledges the overvoltage
    ctl.sensor_reg_enable = !reg_flags[1];
    ctl.wake_summary_bit = glob[`ECS_GLB_WAKE];
    ctl.bus_failure_summary_bit = glob[`ECS_GLB_BUS];
    ctl.regulator_summary_bit = glob[`ECS_GLB_REG];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_ext_wake_set: assert property (evt.ext_wake && st_reg.wake_en[2] |=> wake_flags[2])
    else $error("external wake flag not set");
  a_rise_capture: assert property ($rose(evt.wake_pin) && st_reg.wake_en[1] && $past(rstn) |=>
    wake_flags[1])
    else $error("rise flag not set");
  a_fall_capture: assert property ($fell(evt.wake_pin) && st_reg.wake_en[0] && $past(rstn) |=>
    wake_flags[0])
    else $error("fall flag not set");
  a_uv_sleep_clear: assert property (evt.uv_sleep && !wake_set[1] && !wake_set[0] |=>
    wake_flags[1:0] == 2'b00)
    else $error("wake edge flags survive forced sleep");
  a_bus_set: assert property (evt.bus_dom_to ##1 1'b1 |-> bus_flags[1] && glob[5])
    else $error("bus timeout flag or summary missing");
  a_short_set: assert property (evt.bus_short |=> bus_flags[0])
    else $error("bus short flag not set");
  a_ot_set: assert property (evt.main_ot_sd |=> reg_flags[7] && ctl.regulator_summary_bit)
    else $error("overtemp flag not set");
  a_prewarn_gate: assert property ($rose(reg_flags[6]) |-> $past(evt.main_ot_pw && st_reg.sys_en[2]))
    else $error("prewarning set without capture enable");
  a_main_ov_gate: assert property ($rose(reg_flags[5]) |-> $past(evt.main_ov && st_reg.reg_en[3]))
    else $error("overvoltage set without enable");
  a_main_uv_gate: assert property ($rose(reg_flags[4]) |-> $past(evt.main_uv && st_reg.reg_en[2]))
    else $error("undervoltage set without enable");
  a_sens_pw_gate: assert property ($rose(reg_flags[2]) |-> $past(evt.sens_ot_pw && st_reg.sys_en[2]))
    else $error("sensor prewarning set without enable");
  a_sens_ldo_off: assert property (evt.sens_ov && st_reg.reg_en[1] |=> !ctl.sensor_reg_enable)
    else $error("sensor regulator not disabled");
  a_sens_uv_gate: assert property ($rose(reg_flags[0]) |-> $past(evt.sens_uv && st_reg.reg_en[0]))
    else $error("sensor undervoltage set without enable");
  a_w1c_clear: assert property ($fell(reg_flags[7]) |->
    $past(reg_wr && reg_addr == ADDR_W'(8'h66) && reg_wdata[7]))
    else $error("flag cleared without a written one");
  a_limp_code: assert property (ctl.limp_home_ov_en ==
    !(st_reg.reg_en[6] && st_reg.reg_en[5] && !st_reg.reg_en[4]))
    else $error("limp-home enable decode wrong");
  a_reserved_zero: assert property ((st_reg.sys_en & 8'hb0) == 8'h00 && st_reg.trx2_en[7:1] == 7'h00)
    else $error("reserved enable bit set");
  a_read_latency: assert property (reg_rd && reg_addr == ADDR_W'(8'h05) && !reg_wr |=>
    reg_rdata == $past(st_reg.reg_en))
    else $error("read data mismatch");

  // Enable writes take effect one cycle later, checked against the written data; control levels also checked after reset
  a_sys_en_write: assert property (reg_wr && reg_addr == ADDR_W'(8'h04) |=>
    ctl.batt_uv_en == $past(reg_wdata[6]) && ctl.io_uv_en == $past(reg_wdata[3]) &&
    ctl.spi_fail_en == $past(reg_wdata[1]))
    else $error("system enable write not applied");
  a_rst_sel_write: assert property (reg_wr && reg_addr == ADDR_W'(8'h04) |=>
    ctl.reset_threshold_select == $past(reg_wdata[0]))
    else $error("reset threshold select not written");
  a_reset_levels: assert property (!$past(rstn) |->
    ctl.reset_threshold_select && ctl.limp_home_ov_en && ctl.sensor_reg_enable)
    else $error("control levels wrong after reset");
  a_trx_en_write: assert property (reg_wr && reg_addr == ADDR_W'(8'h23) |=>
    ctl.pn_osc_fail_en == $past(reg_wdata[6]) && ctl.bus_silence_en == $past(reg_wdata[4]) &&
    ctl.lin_wake_en == $past(reg_wdata[2]))
    else $error("transceiver enable write not applied");
  a_can_en_write: assert property (reg_wr && reg_addr == ADDR_W'(8'h23) |=>
    ctl.can_fail_en == $past(reg_wdata[1]) && ctl.can_wake_en == $past(reg_wdata[0]))
    else $error("CAN enable write not applied");
  a_clamp_en_write: assert property (reg_wr && reg_addr == ADDR_W'(8'h34) |=>
    ctl.rx_clamp_en == $past(reg_wdata[0]))
    else $error("clamp enable write not applied");
  a_wake_en_write: assert property (reg_wr && reg_addr == ADDR_W'(8'h4c) |=>
    st_reg.wake_en == ($past(reg_wdata) & 8'h07))
    else $error("wake enable write not applied");

  // Summaries read back and flag clears; a set in the clearing cycle is allowed to win
  a_global_read: assert property (reg_rd && reg_addr == ADDR_W'(8'h60) |=>
    reg_rdata == {2'b00, $past(|bus_flags), 1'b0, $past(|wake_flags), 1'b0, $past(|reg_flags), 1'b0})
    else $error("global summary read wrong");
  a_zero_write_keep: assert property (reg_wr && reg_addr == ADDR_W'(8'h66) && reg_wdata == 8'h00 |=>
    reg_flags == $past(reg_flags | reg_set))
    else $error("zero write changed a flag");
  a_w1c_wake: assert property (reg_wr && reg_addr == ADDR_W'(8'h64) && reg_wdata[2] && !wake_set[2] |=>
    !wake_flags[2])
    else $error("external wake flag not cleared");
  a_w1c_bus: assert property (reg_wr && reg_addr == ADDR_W'(8'h65) && reg_wdata[0] && !bus_set[0] |=>
    !bus_flags[0])
    else $error("bus short flag not cleared");
  a_sens_ot_set: assert property (evt.sens_ot_sd |=> reg_flags[3])
    else $error("sensor overtemp flag not set");
  a_sens_ldo_back: assert property ($fell(reg_flags[1]) |-> ctl.sensor_reg_enable)
    else $error("sensor regulator not re-enabled");
  a_reserved_more: assert property (!st_reg.reg_en[7] && (st_reg.trx_en & 8'ha8) == 8'h00 &&
    st_reg.wake_en[7:3] == 5'h00)
    else $error("reserved enable bit set");

  c_wake_rise: cover property (wake_set[1] ##1 wake_flags[1]);
  c_sleep_drop: cover property (evt.uv_sleep && |wake_flags[1:0]);
  c_clear_ack: cover property (reg_flags[1] ##1 !reg_flags[1]);
  c_set_on_clear: cover property (|(reg_set & reg_clr));
  c_limp_off: cover property (!ctl.limp_home_ov_en);

endmodule

/* ecs_host_model.sv */
// Host model that drives the register strobe port of the event bank
`timescale 1ns/1ps
module ecs_host_model (
  // Clock
  input wire logic sys_clk,
  // Register strobe port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle write strobe; a one in the data acknowledges a flag
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    // Stale values are inverted so a late sample cannot match by luck
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read data is taken one cycle after the strobe edge, once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

/* tb_ecs_event_bank.sv */
// Self-checking bench of the event capture bank driven through a host model
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_ecs_event_bank;
  import ecs_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  ecs_evt_s evt = '0;
  ecs_ctl_s ctl;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  // Offsets, reset values and writable masks of the five enable registers
  logic [7:0] offs [5] = '{8'h04, 8'h05, 8'h23, 8'h34, 8'h4c};
  logic [7:0] rstv [5] = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [5] = '{8'h4f, 8'h7f, 8'h57, 8'h01, 8'h07};

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  ecs_event_bank #(.ADDR_W(8)) ecs_event_bank_inst (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt(evt), .ctl(ctl));

  ecs_host_model ecs_host_model_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Read one register and compare it
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    ecs_host_model_inst.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ecs_host_model_inst.wr(a, d);
  endtask

  // Every detector except uv_sleep high for one cycle, then a full wake pin pulse
  task automatic fire();
    @(negedge sys_clk);
    evt = '1;
    evt.uv_sleep = 1'b0;
    @(negedge sys_clk);
    evt = '0;
    evt.wake_pin = 1'b1;
    repeat (3) @(negedge sys_clk);
    evt.wake_pin = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard; a normal run needs well under a tenth of this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    // Reset contents and the control levels they imply
    for (int i = 0; i < 5; i++) rc(offs[i], rstv[i]);
    rc(8'h64, 8'h00);
    rc(8'h66, 8'h00);
    `CHK(ctl, 15'h0c08)
    // Enables all off: only the ungated detectors may capture
    fire();
    rc(8'h66, 8'h88);
    rc(8'h65, 8'h03);
    rc(8'h64, 8'h00);
    `CHK(ctl, 15'h0c0b)
    // Zero writes leave flags, one writes clear them
    wr(8'h66, 8'h00);
    rc(8'h66, 8'h88);
    wr(8'h66, 8'hff);
    wr(8'h65, 8'hff);
    rc(8'h65, 8'h00);
    rc(8'h66, 8'h00);
    // All enables on; reserved bits must stay zero
    for (int i = 0; i < 5; i++) wr(offs[i], 8'hff);
    for (int i = 0; i < 5; i++) rc(offs[i], msk[i]);
    `CHK(ctl, 15'h7ff8)
    // Global status is read-only, unmapped space reads zero
    wr(8'h60, 8'hff);
    rc(8'h60, 8'h00);
    wr(8'h10, 8'hff);
    rc(8'h10, 8'h00);
    // Every gated event captured
    fire();
    rc(8'h64, 8'h07);
    rc(8'h66, 8'hff);
    rc(8'h60, 8'h2a);
    `CHK(ctl, 15'h7ff7)
    // Clearing the sensor overvoltage flag re-enables its regulator
    wr(8'h66, 8'h02);
    rc(8'h66, 8'hfd);
    `CHK(ctl.sensor_reg_enable, 1'b1)
    // Undervoltage Sleep drops only the two pin edge flags
    @(negedge sys_clk);
    evt.uv_sleep = 1'b1;
    @(negedge sys_clk);
    evt.uv_sleep = 1'b0;
    rc(8'h64, 8'h04);
    // Limp-home code 000 still enables, 110 alone disables
    for (int i = 0; i < 5; i++) wr(offs[i], 8'h00);
    `CHK(ctl, 15'h040f)
    wr(8'h05, 8'h60);
    rc(8'h05, 8'h60);
    `CHK(ctl.limp_home_ov_en, 1'b0)
    wr(8'h05, 8'h10);
    `CHK(ctl.limp_home_ov_en, 1'b1)
    // Acknowledging the external wake empties the wake status
    wr(8'h64, 8'h04);
    rc(8'h64, 8'h00);
    close_out();
  end
endmodule
